//--- ea_pkg.sv
package ea_pkg;

  // ****************************************************************
  // Address space
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] STEP_ONE = 16'h0001;

  // Fixed answer latency in clock cycles, the same for every form
  localparam int RSP_LATENCY = 1;

  // ****************************************************************
  // Addressing forms, sixteen in all
  // ****************************************************************
  typedef enum logic [3:0] {
    register_only_mode       = 4'h0,
    branch_offset_mode       = 4'h1,
    literal_operand_mode     = 4'h2,
    page_zero_mode           = 4'h3,
    full_address_mode        = 4'h4,
    pointer_no_offset        = 4'h5,
    pointer_post_step        = 4'h6,
    pointer_byte_offset      = 4'h7,
    pointer_offset_post_step = 4'h8,
    pointer_word_offset      = 4'h9,
    stack_byte_offset        = 4'ha,
    stack_word_offset        = 4'hb,
    page_to_page_mode        = 4'hc,
    literal_to_page_mode     = 4'hd,
    pointer_step_to_page     = 4'he,
    page_to_pointer_step     = 4'hf
  } ea_mode_t;

  localparam int MODE_COUNT = 16;

endpackage

//--- addr_former.sv
`timescale 1ns/1ps
`default_nettype none
module addr_former
  import ea_pkg::*;
(
  // Form and instruction bytes
  input wire ea_mode_t mode,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [15:0] ptr_pair,
  // Result
  output logic [15:0] addr,
  output logic uses_mem,
  output logic post_step,
  output logic bad_form
);

  // Address formation; every sum wraps inside the 16-bit space
  always_comb begin
    addr = ADDR_RST;
    uses_mem = 1'b1;
    post_step = 1'b0;
    bad_form = 1'b0;
    case (mode)
      register_only_mode, branch_offset_mode, literal_operand_mode: begin
        uses_mem = 1'b0;
      end
      page_zero_mode: begin
        addr = {PAGE_ZERO_HI, byte1};
      end
      full_address_mode: begin
        addr = {byte1, byte2};
      end
      pointer_no_offset: begin
        addr = ptr_pair;
      end
      pointer_post_step: begin
        addr = ptr_pair;
        post_step = 1'b1;
      end
      pointer_byte_offset: begin
        addr = 16'(ptr_pair + {PAGE_ZERO_HI, byte1});
      end
      pointer_offset_post_step: begin
        addr = 16'(ptr_pair + {PAGE_ZERO_HI, byte1});
        post_step = 1'b1;
      end
      pointer_word_offset: begin
        addr = 16'(ptr_pair + {byte1, byte2});
      end
      // Stack and combined moves are not formed here or by the caller; they are flagged as bad forms
      default: begin
        uses_mem = 1'b0;
        bad_form = 1'b1;
      end
    endcase
  end

endmodule
`default_nettype wire

//--- effective_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one flat 64 KB operand space
// - sixteen addressing forms are encoded
// - only page-zero, full-address and pointer forms give address
// - answer latency fixed, same every form
// - register-only form makes no memory access
// - branch offset is one signed byte
// - taken branch adds sign-extended offset to counter
// - tested operand form plus branch offset target
// - transfers use separate source and destination forms
// - literal is one or two instruction bytes
// - page-zero form forces high byte zero
// - pointer word: high at address, low after
// - full-address form takes both instruction bytes
// - no-offset form uses pointer pair directly
// - post-step form accesses then increments pointer
// - byte-offset form adds unsigned byte to pointer
// - offset post-step adds byte, then increments
module effective_address_generator
  import ea_pkg::*;
#(
  // Address width; the formers are built for one 16-bit space only
  parameter int ADDR_BITS = ADDR_W
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Decoded request, one cycle per instruction
  input wire logic req_valid,
  input wire ea_mode_t req_src_mode,
  input wire ea_mode_t req_dst_mode,
  input wire logic req_transfer,
  input wire logic req_wide,
  input wire logic req_branch,
  input wire logic branch_taken,
  input wire logic [7:0] req_byte1,
  input wire logic [7:0] req_byte2,
  input wire logic [7:0] req_offset,
  // Core state
  input wire logic [15:0] ptr_pair,
  input wire logic [15:0] pc_next,
  // Source operand
  output logic rsp_valid_r,
  output logic [15:0] src_addr_r,
  output logic [15:0] src_addr_lo_r,
  output logic src_access_r,
  output logic [15:0] literal_r,
  // Destination operand
  output logic [15:0] dst_addr_r,
  output logic dst_access_r,
  // Pointer and counter updates
  output logic ptr_load_r,
  output logic [15:0] ptr_value_r,
  output logic pc_load_r,
  output logic [15:0] pc_target_r,
  output logic mode_err_r
);

  // Ports and formers are fixed at 16 bits, so any other width is refused
  if (ADDR_BITS != ADDR_W) begin : g_bad_width
    $error("address width must be sixteen bits");
  end

  // ****************************************************************
  // Address formers
  // ****************************************************************
  logic [15:0] form_addr [2];
  logic form_mem [2];
  logic form_step [2];
  logic form_bad [2];
  ea_mode_t form_mode [2];

  // Slot 0 is the source (or tested) operand, slot 1 the destination
  assign form_mode[0] = req_src_mode;
  assign form_mode[1] = req_dst_mode;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_former
      addr_former u_former (
        .mode(form_mode[gi]),
        .byte1(req_byte1),
        .byte2(req_byte2),
        .ptr_pair(ptr_pair),
        .addr(form_addr[gi]),
        .uses_mem(form_mem[gi]),
        .post_step(form_step[gi]),
        .bad_form(form_bad[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Next values
  // ****************************************************************
  logic dst_used;
  logic step_nxt;
  logic [15:0] sext_nxt;
  logic [15:0] literal_nxt;

  // Destination only counts for transfers
  assign dst_used = req_transfer;
  // A transfer steps the pointer once even if both sides name it
  assign step_nxt = form_step[0] | (dst_used & form_step[1]);
  // offset byte is signed two's complement
  assign sext_nxt = {{BYTE_W{req_offset[7]}}, req_offset};
  // wide literal takes two bytes, else one
  assign literal_nxt = req_wide ? {req_byte1, req_byte2} : {PAGE_ZERO_HI, req_byte1};

  // ****************************************************************
  // Answer registers
  // ****************************************************************

  // answer always one cycle after request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= req_valid;
    end
  end

  // operand addresses into the flat space
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      src_addr_r <= ADDR_RST;
      src_addr_lo_r <= ADDR_RST;
      src_access_r <= 1'b0;
      dst_addr_r <= ADDR_RST;
      dst_access_r <= 1'b0;
      mode_err_r <= 1'b0;
    end else if (req_valid) begin
      src_addr_r <= form_addr[0];
      // low byte at the following address
      src_addr_lo_r <= 16'(form_addr[0] + STEP_ONE);
      src_access_r <= form_mem[0];
      dst_addr_r <= form_addr[1];
      dst_access_r <= dst_used & form_mem[1];
      mode_err_r <= form_bad[0] | (dst_used & form_bad[1]);
    end
  end

  // Literal value; held until the next request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      literal_r <= ADDR_RST;
    end else if (req_valid) begin
      literal_r <= literal_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_load_r <= 1'b0;
      ptr_value_r <= ADDR_RST;
    end else begin
      ptr_load_r <= req_valid & step_nxt;
      if (req_valid) begin
        ptr_value_r <= 16'(ptr_pair + STEP_ONE);
      end
    end
  end

  // branch target from offset when taken
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_load_r <= 1'b0;
      pc_target_r <= ADDR_RST;
    end else begin
      pc_load_r <= req_valid & req_branch;
      if (req_valid) begin
        pc_target_r <= (req_branch & branch_taken) ? 16'(pc_next + sext_nxt) : pc_next;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  latency_fixed_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid |=> rsp_valid_r)
    else $error("answer not one cycle after request");

  reg_only_quiet_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == register_only_mode |=> rsp_valid_r && !src_access_r)
    else $error("register-only form made an access");

  page_zero_hi_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == page_zero_mode
    |=> src_access_r && src_addr_r == {8'h00, $past(req_byte1)})
    else $error("page-zero address wrong");

  full_addr_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == full_address_mode
    |=> src_addr_r == {$past(req_byte1), $past(req_byte2)})
    else $error("full address wrong");

  no_offset_ptr_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == pointer_no_offset
    |=> src_addr_r == $past(ptr_pair)
        && ptr_load_r == ($past(req_transfer) && ($past(req_dst_mode) == pointer_post_step
        || $past(req_dst_mode) == pointer_offset_post_step)))
    else $error("no-offset pointer address wrong");

  post_step_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == pointer_post_step
    |=> src_addr_r == $past(ptr_pair) && ptr_load_r
        && ptr_value_r == 16'($past(ptr_pair) + 16'h0001))
    else $error("post-step pointer wrong");

  byte_offset_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == pointer_byte_offset
    |=> src_addr_r == 16'($past(ptr_pair) + {8'h00, $past(req_byte1)})
        && ptr_load_r == ($past(req_transfer) && ($past(req_dst_mode) == pointer_post_step
        || $past(req_dst_mode) == pointer_offset_post_step)))
    else $error("byte-offset address wrong");

  offset_step_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == pointer_offset_post_step
    |=> src_addr_r == 16'($past(ptr_pair) + {8'h00, $past(req_byte1)}) && ptr_load_r)
    else $error("offset post-step wrong");

  pointer_wrap_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && ptr_pair == 16'hffff && req_src_mode == pointer_post_step
    |=> ptr_value_r == 16'h0000)
    else $error("pointer step did not wrap");

  branch_target_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_branch
    |=> pc_load_r && pc_target_r == ($past(branch_taken)
        ? 16'($past(pc_next) + {{8{$past(req_offset[7])}}, $past(req_offset)})
        : $past(pc_next)))
    else $error("branch target wrong");

  word_pair_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rsp_valid_r |-> src_addr_lo_r == 16'(src_addr_r + 16'h0001))
    else $error("word pair addresses not consecutive");

  literal_width_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && !req_wide |=> literal_r[15:8] == 8'h00 && literal_r[7:0] == $past(req_byte1))
    else $error("narrow literal wrong");

  wide_literal_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_wide |=> literal_r == {$past(req_byte1), $past(req_byte2)})
    else $error("wide literal wrong");

  pulse_once_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !req_valid |=> !rsp_valid_r && !ptr_load_r && !pc_load_r)
    else $error("answer pulse without request");

  dest_form_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_transfer && req_dst_mode == page_zero_mode
    |=> dst_access_r && dst_addr_r == {8'h00, $past(req_byte1)})
    else $error("destination address wrong");

  dest_unused_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && !req_transfer |=> !dst_access_r)
    else $error("destination accessed outside a transfer");

  no_branch_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && !req_branch |=> !pc_load_r)
    else $error("counter load without branch");

  back_offset_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_branch && branch_taken && req_offset[7]
    |=> pc_target_r == 16'($past(pc_next) - (16'h0100 - {8'h00, $past(req_offset)})))
    else $error("backward branch target wrong");

  word_lo_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == page_zero_mode
    |=> src_addr_lo_r == 16'({8'h00, $past(req_byte1)} + 16'h0001))
    else $error("word low byte address wrong");

  word_offset_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    req_valid && req_src_mode == pointer_word_offset
    |=> !mode_err_r
        && src_addr_r == 16'($past(ptr_pair) + {$past(req_byte1), $past(req_byte2)}))
    else $error("word-offset address wrong");

endmodule
`default_nettype wire

//--- operand_space_model.sv
`timescale 1ns/1ps
`default_nettype none
module operand_space_model (
  // Two read ports, one per byte of a word
  input wire logic [15:0] rd_addr_hi,
  input wire logic [15:0] rd_addr_lo,
  // Read data
  output logic [7:0] rd_data_hi,
  output logic [7:0] rd_data_lo
);
  // ****************************************************************
  // Flat address space
  // ****************************************************************
  // Content is a fold of the address, so a slip by one shows up
  // one flat space
  assign rd_data_hi = rd_addr_hi[15:8] ^ rd_addr_hi[7:0] ^ 8'h5a;
  assign rd_data_lo = rd_addr_lo[15:8] ^ rd_addr_lo[7:0] ^ 8'h5a;
endmodule
`default_nettype wire

//--- effective_address_generator_bench.sv
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator_bench;
  import ea_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_sys, sys_rst, req_valid, req_transfer, req_wide, req_branch, branch_taken;
  ea_mode_t req_src_mode, req_dst_mode;
  logic [7:0] req_byte1, req_byte2, req_offset, mem_hi, mem_lo;
  logic [15:0] ptr_pair, pc_next, src_addr_r, src_addr_lo_r, literal_r, dst_addr_r;
  logic [15:0] ptr_value_r, pc_target_r;
  logic rsp_valid_r, src_access_r, dst_access_r, ptr_load_r, pc_load_r, mode_err_r;
  int mismatches, num_checks, cycles;

  effective_address_generator i_effective_address_generator (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_src_mode(req_src_mode), .req_dst_mode(req_dst_mode),
    .req_transfer(req_transfer), .req_wide(req_wide), .req_branch(req_branch),
    .branch_taken(branch_taken), .req_byte1(req_byte1), .req_byte2(req_byte2),
    .req_offset(req_offset), .ptr_pair(ptr_pair), .pc_next(pc_next),
    .rsp_valid_r(rsp_valid_r), .src_addr_r(src_addr_r), .src_addr_lo_r(src_addr_lo_r),
    .src_access_r(src_access_r), .literal_r(literal_r), .dst_addr_r(dst_addr_r),
    .dst_access_r(dst_access_r), .ptr_load_r(ptr_load_r), .ptr_value_r(ptr_value_r),
    .pc_load_r(pc_load_r), .pc_target_r(pc_target_r), .mode_err_r(mode_err_r));

  operand_space_model i_operand_space_model (
    .rd_addr_hi(src_addr_r), .rd_addr_lo(src_addr_lo_r),
    .rd_data_hi(mem_hi), .rd_data_lo(mem_lo));

  // ****************************************************************
  // Clock, reset and hang guard
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Under a hundred cycles suffice; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      finish_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request; flags are {transfer, wide, branch, taken}
  task automatic issue(input ea_mode_t sm, input ea_mode_t dm, input logic [3:0] fl,
                       input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] off,
                       input logic [15:0] p, input logic [15:0] pc);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_src_mode <= sm;
    req_dst_mode <= dm;
    {req_transfer, req_wide, req_branch, branch_taken} <= fl;
    req_byte1 <= b1;
    req_byte2 <= b2;
    req_offset <= off;
    ptr_pair <= p;
    pc_next <= pc;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    chk("rsp_valid", {15'h0, rsp_valid_r}, 16'h0001);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_plain_forms;
    issue(register_only_mode, register_only_mode, 4'h0, 8'h12, 8'h34, 8'h00, 16'h1234, 16'h0);
    chk("src_access", {15'h0, src_access_r}, 16'h0000);
    chk("ptr_load", {15'h0, ptr_load_r}, 16'h0000);
    issue(page_zero_mode, register_only_mode, 4'h0, 8'hff, 8'h77, 8'h00, 16'h5555, 16'h0);
    chk("src_access", {15'h0, src_access_r}, 16'h0001);
    chk("page_zero", src_addr_r, 16'h00ff);
    issue(full_address_mode, register_only_mode, 4'h0, 8'hf0, 8'h3b, 8'h00, 16'h0, 16'h0);
    chk("full_addr", src_addr_r, 16'hf03b);
    issue(literal_operand_mode, register_only_mode, 4'h4, 8'h12, 8'h34, 8'h0, 16'h0, 16'h0);
    chk("literal_wide", literal_r, 16'h1234);
    issue(literal_operand_mode, register_only_mode, 4'h0, 8'h55, 8'h34, 8'h0, 16'h0, 16'h0);
    chk("literal_byte", literal_r, 16'h0055);
    issue(stack_byte_offset, register_only_mode, 4'h0, 8'h10, 8'h0, 8'h0, 16'h0, 16'h0);
    chk("mode_err", {15'h0, mode_err_r}, 16'h0001);
  endtask

  task automatic t_pointer_forms;
    issue(pointer_no_offset, register_only_mode, 4'h0, 8'h99, 8'h0, 8'h0, 16'habcd, 16'h0);
    chk("ptr_direct", src_addr_r, 16'habcd);
    chk("ptr_load", {15'h0, ptr_load_r}, 16'h0000);
    issue(pointer_post_step, register_only_mode, 4'h0, 8'h0, 8'h0, 8'h0, 16'hffff, 16'h0);
    chk("post_addr", src_addr_r, 16'hffff);
    chk("post_lo", src_addr_lo_r, 16'h0000);
    chk("post_load", {15'h0, ptr_load_r}, 16'h0001);
    chk("post_value", ptr_value_r, 16'h0000);
    issue(pointer_post_step, register_only_mode, 4'h0, 8'h0, 8'h0, 8'h0, 16'h1234, 16'h0);
    chk("word", {mem_hi, mem_lo}, {8'h12 ^ 8'h34 ^ 8'h5a, 8'h12 ^ 8'h35 ^ 8'h5a});
    issue(pointer_byte_offset, register_only_mode, 4'h0, 8'hf0, 8'h0, 8'h0, 16'h0010, 16'h0);
    chk("byte_off", src_addr_r, 16'h0100);
    issue(pointer_byte_offset, register_only_mode, 4'h0, 8'h80, 8'h0, 8'h0, 16'hff80, 16'h0);
    chk("byte_wrap", src_addr_r, 16'h0000);
    issue(pointer_offset_post_step, register_only_mode, 4'h0, 8'h20, 8'h0, 8'h0, 16'h1000, 16'h0);
    chk("off_post", src_addr_r, 16'h1020);
    chk("off_value", ptr_value_r, 16'h1001);
    chk("off_load", {15'h0, ptr_load_r}, 16'h0001);
  endtask

  task automatic t_branch_and_move;
    logic [7:0] offs[3] = '{8'hfe, 8'h7f, 8'h80};
    logic [15:0] tgts[3] = '{16'h00fe, 16'h017f, 16'h0080};
    for (int i = 0; i < 3; i++) begin
      issue(pointer_no_offset, register_only_mode, 4'h3, 8'h0, 8'h0, offs[i], 16'h0200, 16'h0100);
      chk("pc_load", {15'h0, pc_load_r}, 16'h0001);
      chk("pc_target", pc_target_r, tgts[i]);
      chk("tested_addr", src_addr_r, 16'h0200);
    end
    issue(page_zero_mode, register_only_mode, 4'h2, 8'h40, 8'h0, 8'h80, 16'h0, 16'h0300);
    chk("not_taken", pc_target_r, 16'h0300);
    issue(pointer_post_step, page_zero_mode, 4'h8, 8'h44, 8'h0, 8'h0, 16'h2000, 16'h0);
    chk("move_src", src_addr_r, 16'h2000);
    chk("move_dst", dst_addr_r, 16'h0044);
    chk("dst_access", {15'h0, dst_access_r}, 16'h0001);
  endtask

  task automatic t_more_forms;
    issue(pointer_word_offset, register_only_mode, 4'h0, 8'h12, 8'h34, 8'h0, 16'hf000, 16'h0);
    chk("word_off", src_addr_r, 16'h0234);
    chk("word_off_err", {15'h0, mode_err_r}, 16'h0000);
    issue(page_zero_mode, pointer_post_step, 4'h8, 8'h30, 8'h0, 8'h0, 16'h0400, 16'h0);
    chk("to_ptr_src", src_addr_r, 16'h0030);
    chk("to_ptr_dst", dst_addr_r, 16'h0400);
    chk("to_ptr_step", {15'h0, ptr_load_r}, 16'h0001);
    issue(pointer_post_step, pointer_post_step, 4'h8, 8'h0, 8'h0, 8'h0, 16'h00ff, 16'h0);
    chk("one_step", ptr_value_r, 16'h0100);
    issue(page_zero_mode, stack_word_offset, 4'h8, 8'h01, 8'h0, 8'h0, 16'h0, 16'h0);
    chk("dst_err", {15'h0, mode_err_r}, 16'h0001);
    chk("dst_err_acc", {15'h0, dst_access_r}, 16'h0000);
    issue(page_zero_mode, stack_word_offset, 4'h0, 8'h01, 8'h0, 8'h0, 16'h0, 16'h0);
    chk("dst_unused", {15'h0, mode_err_r}, 16'h0000);
    issue(branch_offset_mode, register_only_mode, 4'h2, 8'h0, 8'h0, 8'h7f, 16'h0, 16'h1000);
    chk("rel_access", {15'h0, src_access_r}, 16'h0000);
    chk("rel_not_taken", pc_target_r, 16'h1000);
    chk("rel_pc_load", {15'h0, pc_load_r}, 16'h0001);
    issue(page_zero_mode, register_only_mode, 4'h0, 8'h10, 8'h0, 8'h0, 16'h0, 16'h0);
    chk("no_branch", {15'h0, pc_load_r}, 16'h0000);
  endtask

  // Two requests on consecutive edges, then the answer pulse must drop
  task automatic t_back_to_back;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_src_mode <= page_zero_mode;
    req_dst_mode <= register_only_mode;
    {req_transfer, req_wide, req_branch, branch_taken} <= 4'h0;
    req_byte1 <= 8'h11;
    @(posedge clk_sys);
    req_byte1 <= 8'h22;
    #1;
    chk("b2b_first", src_addr_r, 16'h0011);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    chk("b2b_second", src_addr_r, 16'h0022);
    chk("b2b_valid", {15'h0, rsp_valid_r}, 16'h0001);
    @(posedge clk_sys);
    #1;
    chk("pulse_end", {15'h0, rsp_valid_r}, 16'h0000);
  endtask

  // Reset in mid-run clears every answer register
  task automatic t_mid_reset;
    issue(pointer_post_step, register_only_mode, 4'h3, 8'h77, 8'h0, 8'h10, 16'h4321, 16'h0500);
    chk("pre_value", ptr_value_r, 16'h4322);
    chk("pre_target", pc_target_r, 16'h0510);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    #1;
    chk("rst_src", src_addr_r, ADDR_RST);
    chk("rst_value", ptr_value_r, ADDR_RST);
    chk("rst_target", pc_target_r, ADDR_RST);
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("rst_valid", {15'h0, rsp_valid_r}, 16'h0000);
    chk("rst_literal", literal_r, ADDR_RST);
    issue(page_zero_mode, register_only_mode, 4'h0, 8'h5a, 8'h0, 8'h0, 16'h0, 16'h0);
    chk("after_rst", src_addr_r, 16'h005a);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {sys_rst, req_valid, req_transfer, req_wide, req_branch, branch_taken} = 6'b100000;
    req_src_mode = register_only_mode;
    req_dst_mode = register_only_mode;
    {req_byte1, req_byte2, req_offset} = 24'h0;
    {ptr_pair, pc_next} = 32'h0;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_plain_forms();
    t_pointer_forms();
    t_branch_and_move();
    t_more_forms();
    t_back_to_back();
    t_mid_reset();
    finish_test();
  end
endmodule
`default_nettype wire
